// ==== core/pfc_pkg.sv ====
package pfc_pkg;

  // ----------------------------------------------------------------
  // Pause frame fields
  // ----------------------------------------------------------------
  localparam logic [47:0] PAUSE_DEST_ADDR = 48'h0180_C200_0001;
  localparam logic [15:0] PAUSE_OPCODE    = 16'h0001;
  localparam logic [15:0] MAC_CTRL_TYPE   = 16'h8808;
  localparam logic [15:0] PAUSE_PAD       = 16'h0000;

  // Word indices of a control frame, first word goes out first.
  localparam logic [2:0] IDX_DA_HIGH = 3'h0;
  localparam logic [2:0] IDX_DA_SA   = 3'h1;
  localparam logic [2:0] IDX_SA_LOW  = 3'h2;
  localparam logic [2:0] IDX_TYPE_OP = 3'h3;
  localparam logic [2:0] IDX_PAUSE   = 3'h4;

  // ----------------------------------------------------------------
  // Register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_PAUSE_VAL = 8'h04;
  localparam logic [7:0] REG_COL_LIMIT = 8'h08;
  localparam logic [7:0] REG_SRC_LOW   = 8'h0C;
  localparam logic [7:0] REG_SRC_HIGH  = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;

  localparam int CTRL_TX_FC_BIT = 0;
  localparam int CTRL_HALF_BIT  = 1;
  localparam int CTRL_RX_FC_BIT = 2;
  localparam int CTRL_GIG_BIT   = 3;
  localparam int STAT_STOP_BIT  = 0;
  localparam int STAT_BP_BIT    = 1;
  localparam int STAT_READY_BIT = 2;

  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  localparam logic [31:0] PAUSE_VAL_RESET = 32'hFFFF_0000;
  localparam logic [4:0]  COL_LIMIT_RESET = 5'h10;

  // ----------------------------------------------------------------
  // Timing: one pause quantum is 512 bit times
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 50;
  localparam int QUANTUM_GIG_NS   = 512;
  localparam int QUANTUM_FAST_NS  = 5120;
  localparam int QUANTUM_GIG_CYC  = (QUANTUM_GIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUANTUM_FAST_CYC = (QUANTUM_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Generator and back-pressure states.
  typedef enum logic [1:0] {
    GEN_IDLE  = 2'b01,
    GEN_READY = 2'b10
  } pfc_gen_state_type;

  typedef enum logic [2:0] {
    BP_OFF   = 3'b001,
    BP_ON    = 3'b010,
    BP_SPENT = 3'b100
  } pfc_bp_state_type;

endpackage

// ==== core/pfc_pause_timer.sv ====
`timescale 1ns/100ps

module pfc_pause_timer
  import pfc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        decode_enable,
  input  wire logic        gigabit_mode,
  input  wire logic        data_frame_transmitting,
  input  wire logic        new_pause_received_toggle,
  input  wire logic [15:0] received_pause_time,
  output logic             transmit_stop,
  output logic             gated_clock_enable,
  output logic [15:0]      pause_remaining
);

  logic        tgl_ff;
  logic [15:0] count_ff;
  logic [7:0]  pre_ff;
  logic [15:0] nxt_count;
  logic [7:0]  nxt_pre;

  // ----------------------------------------------------------------
  // Quantum countdown
  // ----------------------------------------------------------------
  // A new request is seen as a level change on the toggle line.
  wire       new_pause = (new_pause_received_toggle ^ tgl_ff) & decode_enable;
  wire [7:0] quantum   = gigabit_mode ? 8'(QUANTUM_GIG_CYC) : 8'(QUANTUM_FAST_CYC);
  // A data frame already on the wire finishes before the pause starts to run.
  wire       run       = (count_ff != 16'h0000) & ~data_frame_transmitting;
  wire       tick      = run & (pre_ff == 8'h01);

  // Next count: a later pause frame reloads, a zero value releases at once.
  always_comb begin
    nxt_count = count_ff;
    nxt_pre   = pre_ff;
    if (new_pause) begin
      nxt_count = received_pause_time;
      nxt_pre   = quantum;
    end else if (tick) begin
      nxt_count = count_ff - 16'h0001;
      nxt_pre   = quantum;
    end else if (run) begin
      nxt_pre   = pre_ff - 8'h01;
    end
  end

  // Registered outputs, so the stop line never glitches.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgl_ff             <= 1'b0;
      count_ff           <= 16'h0000;
      pre_ff             <= 8'h00;
      transmit_stop      <= 1'b0;
      gated_clock_enable <= 1'b0;
    end else begin
      tgl_ff             <= new_pause_received_toggle;
      count_ff           <= nxt_count;
      pre_ff             <= nxt_pre;
      transmit_stop      <= (nxt_count != 16'h0000);
      gated_clock_enable <= (nxt_count != 16'h0000) | new_pause;
    end
  end

  assign pause_remaining = count_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  zero_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
    new_pause && received_pause_time == 16'h0000 |=> !transmit_stop)
    else $error("Zero pause value did not release the stop.");

  stop_on_pause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    new_pause && received_pause_time != 16'h0000 |=> transmit_stop && count_ff == $past(received_pause_time))
    else $error("Nonzero pause value did not raise the stop.");

  decode_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !decode_enable && count_ff == 16'h0000 |=> !transmit_stop)
    else $error("Stop raised while decoding was disabled.");

  hold_in_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
    data_frame_transmitting && !new_pause |=> count_ff == $past(count_ff))
    else $error("Pause count moved during a data frame.");

endmodule

// ==== core/pfc_backpressure.sv ====
`timescale 1ns/100ps

module pfc_backpressure
  import pfc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       enable,
  input  wire logic       stop_event,
  input  wire logic       resume_event,
  input  wire logic       collision_seen,
  input  wire logic [4:0] collision_limit,
  output logic            backpressure_active
);

  pfc_bp_state_type state_ff;
  pfc_bp_state_type nxt_state;
  logic [4:0]       cnt_ff;
  logic [4:0]       nxt_cnt;
  logic             col_ff;

  // ----------------------------------------------------------------
  // Collision counting
  // ----------------------------------------------------------------
  // Only the rising edge counts, a long collision is one collision.
  wire col_edge = collision_seen & ~col_ff;
  wire at_limit = (5'(cnt_ff + 5'h01) >= collision_limit);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      BP_OFF: begin
        if (enable && stop_event) begin
          nxt_state = BP_ON;
          nxt_cnt   = 5'h00;
        end
      end
      BP_ON: begin
        if (!enable || resume_event) begin
          nxt_state = BP_OFF;
        end else if (col_edge) begin
          nxt_cnt = 5'(cnt_ff + 5'h01);
          if (at_limit) begin
            nxt_state = BP_SPENT;
          end
        end
      end
      BP_SPENT: begin
        if (!enable || resume_event) begin
          nxt_state = BP_OFF;
        end else if (stop_event) begin
          nxt_state = BP_ON;
          nxt_cnt   = 5'h00;
        end
      end
      default: begin
        nxt_state = BP_OFF;
      end
    endcase
  end

  // The limit protects the segment: jamming never runs without bound.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff            <= BP_OFF;
      cnt_ff              <= 5'h00;
      col_ff              <= 1'b0;
      backpressure_active <= 1'b0;
    end else begin
      state_ff            <= nxt_state;
      cnt_ff              <= nxt_cnt;
      col_ff              <= collision_seen;
      backpressure_active <= (nxt_state == BP_ON);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  limit_stops_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == BP_ON && enable && !resume_event && col_edge && at_limit |=> !backpressure_active)
    else $error("Back-pressure kept past the collision limit.");

  half_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable |=> !backpressure_active)
    else $error("Back-pressure active outside half duplex flow control.");

endmodule

// ==== core/pfc_top.sv ====
// Notes on behaviour
// - Pause frames carry destination 01-80-C2-00-00-01.
// - The opcode field holds 00-01.
// - The type field holds 88-08.
// - A 16-bit pause value follows the opcode.
// - A pause blocks only data frames; control frames still go.
// - Pause frames are offered only in full duplex.
// - A decoded pause drives the transmit stop output.
// - Pause frames act only while receive decoding is enabled.
// - Each level change of a request toggle asks for one frame.
// - Stop and resume frames take separate 16-bit pause values.
// - Half duplex back-pressure counts collisions against a 5-bit limit.
// - An output shows when back-pressure is active.
// - Ready asks for a new frame and marks its start.
// - A 3-bit word index selects the 32-bit word, with start and end.
// - Each half drives an enable for its own gated clock.
// - Reset is active low.
// - Gigabit mode sets the pause quantum length.
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps

module pfc_top
  import pfc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [2:0]  control_word_index,
  input  wire logic        resume_request_toggle,
  input  wire logic        stop_request_toggle,
  input  wire logic        collision_seen,
  input  wire logic        new_pause_received_toggle,
  input  wire logic [15:0] received_pause_time,
  input  wire logic        data_frame_transmitting,
  output logic             control_frame_ready,
  output logic             control_frame_start,
  output logic             control_frame_end,
  output logic [31:0]      control_frame_word,
  output logic             backpressure_active,
  output logic             transmit_stop,
  output logic             tx_gated_clock_enable,
  output logic             rx_gated_clock_enable
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Word of the pause frame at a given index; past the end reads zero.
  function automatic logic [31:0] frame_word(input logic [2:0]  idx,
                                             input logic [15:0] pause,
                                             input logic [47:0] src);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      IDX_DA_HIGH: w = PAUSE_DEST_ADDR[47:16];
      IDX_DA_SA:   w = {PAUSE_DEST_ADDR[15:0], src[47:32]};
      IDX_SA_LOW:  w = src[31:0];
      IDX_TYPE_OP: w = {MAC_CTRL_TYPE, PAUSE_OPCODE};
      IDX_PAUSE:   w = {pause, PAUSE_PAD};
      default:     w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Register match on the whole address of a word-aligned access; the upper 24 bits must be zero.
  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] off);
    return (addr[31:8] == 24'h00_0000) && (addr[7:0] == off);
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic [3:0]  ctrl_ff;
  logic [31:0] pause_val_ff;
  logic [4:0]  col_limit_ff;
  logic [31:0] src_low_ff;
  logic [15:0] src_high_ff;
  logic        wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic [15:0] pause_remaining;

  wire        tx_fc_on   = ctrl_ff[CTRL_TX_FC_BIT];
  wire        half_mode  = ctrl_ff[CTRL_HALF_BIT];
  wire        rx_fc_on   = ctrl_ff[CTRL_RX_FC_BIT];
  wire        gig_mode   = ctrl_ff[CTRL_GIG_BIT];
  wire [15:0] resume_pause_value = pause_val_ff[15:0];
  wire [15:0] stop_pause_value   = pause_val_ff[31:16];

  // Every transfer finishes with no wait state and an OKAY answer.
  wire addr_phase = hsel & hready & htrans[1];
  wire wr_take    = addr_phase & hwrite;
  wire rd_take    = addr_phase & ~hwrite;

  wire [31:0] status_word = {pause_remaining, 13'h0000, control_frame_ready,
                             backpressure_active, transmit_stop};
  wire [31:0] rd_mux =
    reg_hit(haddr, REG_CTRL)      ? {28'h000_0000, ctrl_ff} :
    reg_hit(haddr, REG_PAUSE_VAL) ? pause_val_ff :
    reg_hit(haddr, REG_COL_LIMIT) ? {27'h000_0000, col_limit_ff} :
    reg_hit(haddr, REG_SRC_LOW)   ? src_low_ff :
    reg_hit(haddr, REG_SRC_HIGH)  ? {16'h0000, src_high_ff} :
    reg_hit(haddr, REG_STATUS)    ? status_word : 32'h0000_0000;

  // Address phase is captured; the write lands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h0000_0000;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b0;
      hresp      <= 1'b0;
    end else begin
      wr_pend_ff <= wr_take;
      wr_addr_ff <= haddr;
      hrdata     <= rd_take ? rd_mux : 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  // Software-owned settings.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff      <= CTRL_RESET;
      pause_val_ff <= PAUSE_VAL_RESET;
      col_limit_ff <= COL_LIMIT_RESET;
      src_low_ff   <= 32'h0000_0000;
      src_high_ff  <= 16'h0000;
    end else if (wr_pend_ff) begin
      if (reg_hit(wr_addr_ff, REG_CTRL)) begin
        ctrl_ff <= hwdata[3:0];
      end
      if (reg_hit(wr_addr_ff, REG_PAUSE_VAL)) begin
        pause_val_ff <= hwdata;
      end
      if (reg_hit(wr_addr_ff, REG_COL_LIMIT)) begin
        col_limit_ff <= hwdata[4:0];
      end
      if (reg_hit(wr_addr_ff, REG_SRC_LOW)) begin
        src_low_ff <= hwdata;
      end
      if (reg_hit(wr_addr_ff, REG_SRC_HIGH)) begin
        src_high_ff <= hwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Request detection
  // ----------------------------------------------------------------
  // Bit 0 is resume, bit 1 is stop.
  logic [1:0] req_tgl_ff;
  logic [1:0] pending_ff;
  logic [1:0] nxt_pending;
  wire  [1:0] req_now = {stop_request_toggle, resume_request_toggle};
  wire  [1:0] req_changed;
  wire        full_duplex_fc = tx_fc_on & ~half_mode;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_req
      assign req_changed[g] = req_now[g] ^ req_tgl_ff[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Frame generator
  // ----------------------------------------------------------------
  pfc_gen_state_type state_ff;
  pfc_gen_state_type nxt_state;
  logic [15:0]       frame_pause_ff;
  logic [15:0]       nxt_frame_pause;
  logic [1:0]        taken;

  // The frame is consumed when the last word is asked for.
  wire frame_done = (state_ff == GEN_READY) && (control_word_index == IDX_PAUSE);

  // Stop requests go first; a request cleared on issue may set again at once.
  always_comb begin
    nxt_state       = state_ff;
    nxt_frame_pause = frame_pause_ff;
    taken           = 2'b00;
    case (state_ff)
      GEN_IDLE: begin
        if (full_duplex_fc && pending_ff != 2'b00) begin
          nxt_state = GEN_READY;
          taken     = pending_ff[1] ? 2'b10 : 2'b01;
          nxt_frame_pause = pending_ff[1] ? stop_pause_value : resume_pause_value;
        end
      end
      GEN_READY: begin
        if (frame_done || !full_duplex_fc) begin
          nxt_state = GEN_IDLE;
        end
      end
      default: begin
        nxt_state = GEN_IDLE;
      end
    endcase
    // Set wins over clear; requests seen outside full duplex are dropped.
    nxt_pending = (pending_ff & ~taken) | (req_changed & {2{full_duplex_fc}});
  end

  // Word and markers follow the index one cycle later; transmit_stop is
  // not looked at here, so control frames still go while paused.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff              <= GEN_IDLE;
      frame_pause_ff        <= 16'h0000;
      req_tgl_ff            <= 2'b00;
      pending_ff            <= 2'b00;
      control_frame_ready   <= 1'b0;
      control_frame_start   <= 1'b0;
      control_frame_end     <= 1'b0;
      control_frame_word    <= 32'h0000_0000;
      tx_gated_clock_enable <= 1'b0;
    end else begin
      state_ff              <= nxt_state;
      frame_pause_ff        <= nxt_frame_pause;
      req_tgl_ff            <= req_now;
      pending_ff            <= nxt_pending;
      control_frame_ready   <= (nxt_state == GEN_READY);
      control_frame_start   <= (state_ff == GEN_READY) && (control_word_index == IDX_DA_HIGH);
      control_frame_end     <= frame_done;
      control_frame_word    <= frame_word(control_word_index, frame_pause_ff,
                                          {src_high_ff, src_low_ff});
      tx_gated_clock_enable <= (nxt_state == GEN_READY) | (nxt_pending != 2'b00) |
                               (req_changed != 2'b00) | backpressure_active;
    end
  end

  // ----------------------------------------------------------------
  // Half duplex back-pressure and pause decoder
  // ----------------------------------------------------------------
  pfc_backpressure u_backpressure (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .enable              (tx_fc_on & half_mode),
    .stop_event          (req_changed[1]),
    .resume_event        (req_changed[0]),
    .collision_seen      (collision_seen),
    .collision_limit     (col_limit_ff),
    .backpressure_active (backpressure_active)
  );

  pfc_pause_timer u_pause_timer (
    .hclk                      (hclk),
    .hresetn                   (hresetn),
    .decode_enable             (rx_fc_on),
    .gigabit_mode              (gig_mode),
    .data_frame_transmitting   (data_frame_transmitting),
    .new_pause_received_toggle (new_pause_received_toggle),
    .received_pause_time       (received_pause_time),
    .transmit_stop             (transmit_stop),
    .gated_clock_enable        (rx_gated_clock_enable),
    .pause_remaining           (pause_remaining)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  no_half_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
    half_mode |=> !control_frame_ready)
    else $error("Control frame offered in half duplex.");

  one_per_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    full_duplex_fc && req_changed[1] |=> pending_ff[1])
    else $error("Stop request toggle lost.");

  header_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
    control_word_index == IDX_DA_HIGH |=> control_frame_word == PAUSE_DEST_ADDR[47:16])
    else $error("Wrong destination address word.");

  opcode_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
    control_word_index == IDX_TYPE_OP |=> control_frame_word[15:0] == PAUSE_OPCODE)
    else $error("Wrong opcode in control frame.");

  type_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
    control_word_index == IDX_TYPE_OP |=> control_frame_word[31:16] == MAC_CTRL_TYPE)
    else $error("Wrong type in control frame.");

  pause_word_a: assert property (@(posedge hclk) disable iff (!hresetn)
    control_word_index == IDX_PAUSE |=> control_frame_word[31:16] == $past(frame_pause_ff))
    else $error("Pause value missing from control frame.");

  stop_value_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff == GEN_IDLE && nxt_state == GEN_READY && pending_ff[1] |=> frame_pause_ff == $past(stop_pause_value))
    else $error("Stop frame took the wrong pause value.");

  end_marks_a: assert property (@(posedge hclk) disable iff (!hresetn)
    frame_done |=> control_frame_end && !control_frame_ready)
    else $error("End marker missing on the last word.");

endmodule

// ==== tb/pfc_txfsm_model.sv ====
`timescale 1ns/100ps

// Transmit state machine stand-in: it fetches each offered control frame one word at a time.
module pfc_txfsm_model (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  input  wire logic  control_frame_ready,
  input  wire logic  data_frame_request,
  output logic [2:0] control_word_index,
  output logic       data_frame_transmitting
);
  logic [2:0] step_ff;

  // Index 7 parks on an empty word, so an idle model never fakes a start marker.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_ff            <= 3'h0;
      control_word_index <= 3'h7;
    end else if (step_ff == 3'h0 && control_frame_ready) begin
      step_ff            <= 3'h1;
      control_word_index <= 3'h0;
    end else if (step_ff != 3'h0 && step_ff < 3'h5) begin
      step_ff            <= step_ff + 3'h1;
      control_word_index <= step_ff;
    end else if (step_ff == 3'h5) begin
      step_ff            <= control_frame_ready ? 3'h5 : 3'h0;
      control_word_index <= 3'h7;
    end
  end

  // Data frames go only while no control frame is being fetched.
  assign data_frame_transmitting = data_frame_request & (step_ff == 3'h0);
endmodule

// ==== tb/pause_flow_control_tb_top.sv ====
`timescale 1ns/100ps

module pause_flow_control_tb_top;
  import pfc_pkg::*;

  logic        hresetn, hsel, hwrite, hreadyout, hresp, rtgl, stgl, col, ptgl, ready, sop, eop, bp;
  logic        hclk = 1'b0, rdph = 1'b0, stop, dft, dreq, tgce, rgce;
  logic [1:0]  htrans;
  logic [2:0]  idx;
  logic [15:0] ptime;
  logic [31:0] haddr, hwdata, hrdata, cword, pv;
  logic [47:0] src;
  logic [31:0] fq[$], rq[$];
  int          mismatches, total_checks, fpos;
  int          seed = 20848;

  pfc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .control_word_index(idx), .resume_request_toggle(rtgl), .stop_request_toggle(stgl), .collision_seen(col),
    .new_pause_received_toggle(ptgl), .received_pause_time(ptime), .data_frame_transmitting(dft),
    .control_frame_ready(ready), .control_frame_start(sop), .control_frame_end(eop), .control_frame_word(cword),
    .backpressure_active(bp), .transmit_stop(stop), .tx_gated_clock_enable(tgce), .rx_gated_clock_enable(rgce));

  pfc_txfsm_model u_fsm (.hclk(hclk), .hresetn(hresetn), .control_frame_ready(ready), .control_word_index(idx),
    .data_frame_request(dreq), .data_frame_transmitting(dft));

  // ----------------------------------------------------------------
  // Checking and bus helpers
  // ----------------------------------------------------------------
  always #25 hclk = ~hclk;

  task automatic chk(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One single transfer; the leading edge leaves an idle cycle, so a read never races a write.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : ~d;
    if (!wr) rq.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic expect_frame(input logic [15:0] v);
    fq.push_back(PAUSE_DEST_ADDR[47:16]);
    fq.push_back({PAUSE_DEST_ADDR[15:0], src[47:32]});
    fq.push_back(src[31:0]);
    fq.push_back({MAC_CTRL_TYPE, PAUSE_OPCODE});
    fq.push_back({v, PAUSE_PAD});
  endtask

  task automatic pause(input logic [15:0] v);
    @(posedge hclk);
    ptime <= v;
    ptgl  <= ~ptgl;
    repeat (4) @(posedge hclk);
  endtask

  // Watcher: takes the oldest noted result whenever read data or a frame word appears.
  always @(posedge hclk) begin
    if (rdph) chk(hrdata === rq.pop_front() && hresp === 1'b0, "register read");
    rdph <= hsel && htrans[1] && !hwrite && hreadyout;
    if (sop || fpos > 0) begin
      if (fpos == 0) chk(ready === 1'b1, "start without ready");
      if (fpos == 0) chk(tgce === 1'b1, "tx clock enable low in frame");
      chk(fq.size() > 0 && cword === fq.pop_front(), "control frame word");
      if (fpos == 4) chk(eop === 1'b1, "frame end marker");
      fpos <= (fpos == 4) ? 0 : fpos + 1;
    end
  end

  // A hang is cut short well beyond the few hundred cycles the sequence needs.
  initial begin
    #100000;
    mismatches++;
    $display("MISMATCH at %0t: timeout", $time);
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, rtgl, stgl, col, ptgl, dreq} = '0;
    {htrans, haddr, hwdata, ptime} = '0;
    src = {$random(seed), $random(seed)} >> 16;
    pv  = $random(seed);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, REG_CTRL, 32'h0);
    bus(1'b0, REG_PAUSE_VAL, PAUSE_VAL_RESET);
    bus(1'b0, REG_COL_LIMIT, {27'h0, COL_LIMIT_RESET});
    bus(1'b0, 8'h18, 32'h0);
    bus(1'b1, REG_SRC_LOW, src[31:0]);
    bus(1'b1, REG_SRC_HIGH, {16'h0, src[47:32]});
    bus(1'b1, REG_PAUSE_VAL, pv);
    bus(1'b0, REG_PAUSE_VAL, pv);
    bus(1'b1, REG_CTRL, 32'h1);
    expect_frame(pv[31:16]);
    expect_frame(pv[15:0]);
    @(posedge hclk);
    stgl <= ~stgl;
    rtgl <= ~rtgl;
    repeat (30) @(posedge hclk);
    chk(fq.size() == 0, "both frames sent");
    bus(1'b1, REG_COL_LIMIT, 32'h3);
    bus(1'b1, REG_CTRL, 32'h3);
    @(posedge hclk);
    stgl <= ~stgl;
    repeat (3) @(posedge hclk);
    chk(bp === 1'b1, "backpressure on");
    repeat (3) begin
      @(posedge hclk) col <= 1'b1;
      @(posedge hclk) col <= 1'b0;
    end
    repeat (3) @(posedge hclk);
    chk(bp === 1'b0, "collision limit");
    stgl <= ~stgl;
    repeat (3) @(posedge hclk);
    chk(bp === 1'b1, "backpressure restart");
    rtgl <= ~rtgl;
    repeat (3) @(posedge hclk);
    chk(bp === 1'b0, "resume ends backpressure");
    bus(1'b1, REG_CTRL, 32'hD);
    pause(16'h2);
    chk(stop === 1'b1, "stop raised");
    chk(rgce === 1'b1, "rx clock enable on");
    // A data frame on the wire freezes the countdown for ten cycles.
    dreq <= 1'b1;
    repeat (10) @(posedge hclk);
    dreq <= 1'b0;
    repeat (18) @(posedge hclk);
    chk(stop === 1'b1, "stop held across data frame");
    repeat (3) @(posedge hclk);
    chk(stop === 1'b0, "stop released");
    chk(rgce === 1'b0, "rx clock enable off");
    bus(1'b1, REG_CTRL, 32'h5);
    pause(16'h2);
    repeat (30) @(posedge hclk);
    chk(stop === 1'b1, "slow quantum");
    expect_frame(pv[31:16]);
    stgl <= ~stgl;
    repeat (20) @(posedge hclk);
    chk(fq.size() == 0, "control frame while paused");
    pause(16'h0);
    chk(stop === 1'b0, "zero releases");
    bus(1'b1, REG_CTRL, 32'h1);
    pause(16'h5);
    chk(stop === 1'b0, "decode disabled");
    give_verdict();
  end
endmodule
